// file: src/emb_bus.sv
// external memory bus engine: multiplexed address/data with control strobes
`timescale 1ns/1ps
module emb_bus
	import emb_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// mode select
	input wire emb_mode_t mode,
	// core request
	input wire logic req_valid,
	input wire emb_req_t req,
	input wire logic [15:0] internal_word,
	output logic req_ready,
	output logic rsp_valid,
	output logic [15:0] rsp_data,
	// general i/o view of the ports
	input wire logic [15:0] gpio_ad_out,
	input wire logic [15:0] gpio_ad_oe,
	input wire logic [2:0] gpio_ctl_out,
	input wire logic [2:0] gpio_ctl_oe,
	output logic [15:0] gpio_ad_in,
	output logic [2:0] gpio_ctl_in,
	// low and high multiplexed ports
	input wire logic [15:0] ad_in,
	output logic [15:0] ad_out,
	output logic [15:0] ad_oe,
	// bus control port
	input wire logic [2:0] ctl_in,
	output logic [2:0] ctl_out,
	output logic [2:0] ctl_oe,
	// bus mode indication
	output logic bus_mode
);
	emb_phase_t state_q, state_d;
	emb_req_t cur_q;
	logic [15:0] ad_sync, ctl_sync16;
	logic [15:0] ad_out_q, ad_out_d, ad_oe_q, ad_oe_d;
	emb_ctl_t ctl_q, ctl_d;
	logic [2:0] ctl_oe_q, ctl_oe_d;
	logic bus_mode_q, rsp_valid_q, ready_q, late_q;
	logic [15:0] rsp_data_q, gpio_ad_in_q;
	logic [2:0] gpio_ctl_in_q;

	// pins cross into clk domain
	emb_sync #(.WIDTH(16)) u_ad_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din(ad_in),
		.dout(ad_sync)
	);
	emb_sync #(.WIDTH(16)) u_ctl_sync (
		.clk(clk),
		.rst_n(rst_n),
		.din({13'h0000, ctl_in}),
		.dout(ctl_sync16)
	);

	wire bus_sel = (mode == EMB_MODE_EXTENDED) || (mode == EMB_MODE_MICROPROCESSOR);
	wire start = bus_mode_q && req_valid && (state_q == EMB_PH_END || state_q == EMB_PH_ADDR)
		&& ready_q;
	wire in_cycle = bus_mode_q && !ready_q;
	wire internal_fetch = cur_q.internal && (mode == EMB_MODE_EXTENDED);
	wire [15:0] read_word = internal_fetch ? internal_word : ad_sync;

	always_comb begin
		state_d = state_q;
		ad_out_d = ad_out_q;
		ad_oe_d = ad_oe_q;
		ctl_d = ctl_q;
		ctl_oe_d = ctl_oe_q;
		if (!bus_mode_q) begin
			// port registers steer pins only outside bus mode
			ad_out_d = gpio_ad_out;
			ad_oe_d = gpio_ad_oe;
			ctl_d = gpio_ctl_out;
			ctl_oe_d = gpio_ctl_oe;
			state_d = EMB_PH_ADDR;
		end else begin
			ctl_oe_d = EMB_CTL_OUT_EN;
			case (state_q)
				EMB_PH_ADDR: begin
					ctl_d = EMB_CTL_IDLE;
					ad_oe_d = 16'h0000;
					if (start) begin
						ad_out_d = req.addr;
						ad_oe_d = 16'hffff;
						ctl_d.ale = 1'b1;
						state_d = EMB_PH_HOLD;
					end
				end
				EMB_PH_HOLD: begin
					ctl_d.ale = 1'b0;
					ad_oe_d = cur_q.write ? 16'hffff : 16'h0000;
					ad_out_d = cur_q.write ? cur_q.wdata : ad_out_q;
					state_d = EMB_PH_DATA;
				end
				EMB_PH_DATA: begin
					// strobes run for internal fetches too
					ctl_d.oe_n = cur_q.write;
					ctl_d.wr_n = !cur_q.write;
					state_d = EMB_PH_END;
				end
				EMB_PH_END: begin
					ctl_d = EMB_CTL_IDLE;
					ad_oe_d = 16'h0000;
					state_d = EMB_PH_ADDR;
				end
				default: begin
					state_d = EMB_PH_ADDR;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state_q <= EMB_PH_ADDR;
			bus_mode_q <= 1'b0;
			cur_q <= '0;
			ad_out_q <= EMB_AD_RESET;
			ad_oe_q <= 16'h0000;
			ctl_q <= EMB_CTL_IDLE;
			ctl_oe_q <= 3'b000;
			ready_q <= 1'b1;
			late_q <= 1'b0;
			rsp_valid_q <= 1'b0;
			rsp_data_q <= 16'h0000;
			gpio_ad_in_q <= 16'h0000;
			gpio_ctl_in_q <= 3'b000;
		end else begin
			state_q <= state_d;
			bus_mode_q <= bus_sel;
			ad_out_q <= ad_out_d;
			ad_oe_q <= ad_oe_d;
			ctl_q <= ctl_d;
			ctl_oe_q <= ctl_oe_d;
			gpio_ad_in_q <= ad_sync;
			gpio_ctl_in_q <= ctl_sync16[2:0];
			rsp_valid_q <= 1'b0;
			if (start) begin
				cur_q <= req;
				ready_q <= 1'b0;
			end else if (!bus_mode_q) begin
				ready_q <= 1'b1;
				late_q <= 1'b0;
			end else if (in_cycle && state_q == EMB_PH_END) begin
				// data phase reaches the sync output one cycle later
				late_q <= 1'b1;
			end else if (late_q) begin
				late_q <= 1'b0;
				ready_q <= 1'b1;
				rsp_valid_q <= !cur_q.write;
				rsp_data_q <= read_word;
			end
		end
	end

	assign req_ready = ready_q;
	assign rsp_valid = rsp_valid_q;
	assign rsp_data = rsp_data_q;
	assign gpio_ad_in = gpio_ad_in_q;
	assign gpio_ctl_in = gpio_ctl_in_q;
	assign ad_out = ad_out_q;
	assign ad_oe = ad_oe_q;
	assign ctl_out = ctl_q;
	assign ctl_oe = ctl_oe_q;
	assign bus_mode = bus_mode_q;
endmodule // emb_bus

// file: src/emb_pkg.sv
// package for the external memory bus interface
package emb_pkg;
	// operating modes
	typedef enum logic [1:0] {
		EMB_MODE_MICROCONTROLLER = 2'h0,
		EMB_MODE_EXTENDED = 2'h1,
		EMB_MODE_MICROPROCESSOR = 2'h2,
		EMB_MODE_RESERVED = 2'h3
	} emb_mode_t;

	// bus cycle phases, one-hot
	typedef enum logic [3:0] {
		EMB_PH_ADDR = 4'b0001,
		EMB_PH_HOLD = 4'b0010,
		EMB_PH_DATA = 4'b0100,
		EMB_PH_END = 4'b1000
	} emb_phase_t;

	// core request for one bus cycle
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic write;
		logic internal;
	} emb_req_t;

	// control strobe pins of the bus control port
	typedef struct packed {
		logic wr_n;
		logic oe_n;
		logic ale;
	} emb_ctl_t;

	localparam int EMB_CTL_ALE_BIT = 0;
	localparam int EMB_CTL_OE_BIT = 1;
	localparam int EMB_CTL_WR_BIT = 2;
	localparam logic [15:0] EMB_AD_RESET = 16'h0000;
	localparam logic [2:0] EMB_CTL_IDLE = 3'b110;
	localparam logic [2:0] EMB_CTL_OUT_EN = 3'b111;
endpackage

// file: src/emb_sync.sv
// two flip-flop synchroniser, parameterised width
`timescale 1ns/1ps
module emb_sync #(
	parameter int WIDTH = 16
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// data
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '0;
			dout <= '0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule // emb_sync

// file: tb/emb_bus_asserts.sv
// bus checker
`timescale 1ns/1ps
module emb_bus_asserts
	import emb_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic rst_n,
	input wire logic req_valid,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic bus_mode,
	input wire logic [15:0] ad_oe,
	input wire logic [2:0] ctl_out
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	wire logic take = req_valid && req_ready && bus_mode;
	property p_idle;
		bus_mode [*2] ##0 req_ready |-> ctl_out == EMB_CTL_IDLE;
	endproperty
	a_idle: assert property (p_idle) else $error("idle");
	property p_nocon;
		bus_mode [*2] ##0 !ctl_out[1] |-> ad_oe == 16'h0000;
	endproperty
	a_nocon: assert property (p_nocon) else $error("clash");
	property p_addr;
		take |=> ctl_out[0] && ad_oe == 16'hffff ##1 !ctl_out[0];
	endproperty
	a_addr: assert property (p_addr) else $error("addr");
	property p_strb;
		take |-> ##3 ctl_out[1] ^ ctl_out[2];
	endproperty
	a_strb: assert property (p_strb) else $error("strobe");
	property p_rdy;
		take |=> !req_ready [*4] ##1 req_ready;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready");
	property p_rsp;
		rsp_valid |=> !rsp_valid;
	endproperty
	a_rsp: assert property (p_rsp) else $error("response pulse");
endmodule // emb_bus_asserts

// file: tb/emb_mem.sv
// external memory behind address latches
`timescale 1ns/1ps
module emb_mem (
	// bus pins
	input wire logic clk,
	input wire logic [15:0] ad_out,
	input wire logic [15:0] ad_oe,
	input wire logic [2:0] ctl_out,
	output logic [15:0] ad_in
);
	logic [15:0] lat_q;
	logic [15:0] mem_q [4];
	always_ff @(posedge clk) begin
		if (ctl_out[0])
			lat_q <= ad_out;
		if (!ctl_out[2])
			mem_q[lat_q[1:0]] <= ad_out;
	end
	assign ad_in = |ad_oe ? ad_out : mem_q[lat_q[1:0]];
endmodule // emb_mem

// file: tb/tb_top.sv
// bench for the bus engine
`timescale 1ns/1ps
module tb_top
	import emb_pkg::*;
	;
	typedef struct packed {emb_mode_t m; emb_req_t r; logic [15:0] e;} emb_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic req_valid = 1'b0;
	emb_mode_t mode = EMB_MODE_EXTENDED;
	emb_req_t req = '0;
	logic req_ready, rsp_valid, bus_mode;
	logic [15:0] rsp_data, ad_in, ad_out, ad_oe;
	logic [2:0] ctl_out;
	int failures = 0;
	int num_checks = 0;
	emb_row_t rows [4] = '{
		'{EMB_MODE_EXTENDED, '{16'h0012, 16'ha5c3, 1'b1, 1'b0}, 16'h0000},
		'{EMB_MODE_EXTENDED, '{16'h0012, 16'h0000, 1'b0, 1'b0}, 16'ha5c3},
		'{EMB_MODE_EXTENDED, '{16'h0012, 16'h0000, 1'b0, 1'b1}, 16'h7e81},
		'{EMB_MODE_MICROPROCESSOR, '{16'h0012, 16'h0000, 1'b0, 1'b1}, 16'ha5c3}
	};
	always #2 clk = ~clk;
	emb_bus dut (.clk, .rst_n, .mode, .req_valid, .req, .internal_word(16'h7e81),
		.req_ready, .rsp_valid, .rsp_data, .gpio_ad_out(16'h3c3c), .gpio_ad_oe(16'h00ff),
		.gpio_ctl_out(3'b100), .gpio_ctl_oe(3'b111), .gpio_ad_in(), .gpio_ctl_in(),
		.ad_in, .ad_out, .ad_oe, .ctl_in(ctl_out), .ctl_out, .ctl_oe(), .bus_mode);
	emb_mem u_mem (.clk, .ad_out, .ad_oe, .ctl_out, .ad_in);
	task automatic chk(input logic ok);
		num_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("CHECK FAILED at %0t: mismatch", $time);
		end
	endtask
	task automatic test_done;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic run(input emb_row_t w);
		int n;
		logic got;
		got = 1'b0;
		mode = w.m;
		req = w.r;
		req_valid = 1'b1;
		for (n = 0; n < 20; n++) begin
			@(negedge clk);
			if (req_ready === 1'b1 && bus_mode === 1'b1)
				break;
		end
		@(negedge clk);
		req_valid = 1'b0;
		repeat (6) begin
			got |= rsp_valid === 1'b1;
			@(negedge clk);
		end
		chk(n < 20 && got === !w.r.write && (w.r.write || rsp_data === w.e) && !ad_oe);
		if (n == 20)
			test_done;
	endtask
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		foreach (rows[i])
			run(rows[i]);
		mode = EMB_MODE_MICROCONTROLLER;
		req_valid = 1'b1;
		repeat (4) @(negedge clk);
		chk(!rsp_valid && ad_oe === 16'h00ff && ad_out === 16'h3c3c);
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		chk(ctl_out === EMB_CTL_IDLE && req_ready === 1'b1);
		test_done;
	end
endmodule // tb_top
bind emb_bus emb_bus_asserts u_chk (.clk, .rst_n, .req_valid, .req_ready, .rsp_valid, .bus_mode,
	.ad_oe, .ctl_out);
